// *** src/vr_seq_pkg.sv ***
// Constants, register map and state encodings of the regulator sequencer.
// Assumes a single 25 MHz clock and synchronised comparator inputs.
package vr_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int START_DELAY_US = 200;
  localparam int START_CYC      = START_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int STOP_DELAY_NS  = 300;
  localparam int STOP_CYC       = (STOP_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OFF_PULSE_CYC  = 1;
  localparam int DLY_W          = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SLEW      = 8'h40;
  localparam int         SLEW_BIT       = 1;
  localparam logic [7:0] ADDR_BOOT      = 8'h45;
  localparam int         BOOT_LSB       = 1;
  localparam logic [7:0] ADDR_LOW       = 8'h4F;
  localparam int         LOW_LSB        = 4;
  localparam logic [7:0] ADDR_BAL_FIRST = 8'h11;
  localparam logic [7:0] ADDR_BAL_LAST  = 8'h20;
  localparam int         BAL_REGS       = 16;
  localparam logic [7:0] ADDR_TBAL_A    = 8'h55;
  localparam int         TBAL_A_LSB     = 3;
  localparam logic [7:0] ADDR_TBAL_B    = 8'h5F;
  localparam int         TBAL_B_LSB     = 0;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         PHASE_W        = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_OFF     = 4'h0,
    S_STRAP   = 4'h1,
    S_DELAY   = 4'h3,
    S_SOFT    = 4'h2,
    S_RUN     = 4'h6,
    S_STANDBY = 4'h7,
    S_STOP    = 4'h5,
    S_PULSE   = 4'h4
  } seq_state_t;

  typedef enum logic [1:0] {
    MODE_LOW  = 2'h0,
    MODE_AUTO = 2'h1,
    MODE_HIGH = 2'h3
  } phase_mode_t;

endpackage : vr_seq_pkg

// *** src/phase_count_select.sv ***
// Chooses the running phase count from mode, boot state, straps and fields.
// Assumes boot_code, low_code and max_code are flop outputs of the sequencer; mode, boot and auto_code are not.
`timescale 1ns/1ps
module phase_count_select
  import vr_seq_pkg::*;
(
  input  wire vr_seq_pkg::phase_mode_t mode,
  input  wire logic                    boot,
  input  wire logic [PHASE_W-1:0]      boot_code,
  input  wire logic [PHASE_W-1:0]      low_code,
  input  wire logic [PHASE_W-1:0]      max_code,
  input  wire logic [PHASE_W-1:0]      auto_code,
  output logic      [PHASE_W-1:0]      count_code
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  function automatic logic [PHASE_W-1:0] clamp(input logic [PHASE_W-1:0] c,
                                               input logic [PHASE_W-1:0] m);
    clamp = (c > m) ? m : c;
  endfunction : clamp

  always_comb
  begin
    if (boot)
      count_code = clamp(boot_code, max_code);                 // [R14] [R16]
    else
    begin
      unique case (mode)
        MODE_HIGH: count_code = max_code;                      // [R21]
        MODE_AUTO: count_code = clamp(auto_code, max_code);    // [R22]
        default:   count_code = clamp(low_code, max_code);     // [R20]
      endcase
    end
  end

endmodule : phase_count_select

// *** src/vr_sequence_and_phase_mode_ctrl.sv ***
// Power-on/off sequencer, reference-adjust gating and phase mode control.
// Assumes comparator results are already synchronous to clk.
`timescale 1ns/1ps

// What this block does
// R01 - Enable re-toggle after first power-on skips strap detection.
// R02 - Wait about 200 us after enable before soft-start.
// R03 - Phases tri-stated in start delay; nominal reference driven in smart-stage mode.
// R04 - Re-toggle uses slew latched from ramp strap at first power-on.
// R05 - Configuration kept across enable toggles, cleared only by power-on reset.
// R06 - Register access only after power-on sequence; host waits too.
// R07 - Enable low: stop switching after 300 ns, tri-state all phases.
// R08 - Power-good pulled low when switching stops.
// R09 - One short low pulse on every phase before tri-state.
// R10 - Output-sense discharge switch on at power-off.
// R11 - Reference output discharged at enable low in smart-stage mode.
// R12 - Reference-adjust output follows the duty voltage-select input.
// R13 - Reference-adjust only after power-good; high impedance before.
// R14 - Boot mode ignores duty input and runs the boot phase count.
// R15 - Reference below standby threshold: standby, phases tri-stated.
// R16 - Exit standby above exit threshold, reboot with boot phase count.
// R17 - Power-good stays high throughout standby.
// R18 - Per-phase balance registers and total balance gain fields provided.
// R19 - Host drives power-state input inside the recommended bands.
// R20 - Low-phase mode runs strap or register count, 000 one phase.
// R21 - High-phase mode runs maximum count sensed at first power-on.
// R22 - Automatic shedding only in middle band, tracking load.
// R23 - Power-good latched at reference after soft-start, dropped on trips.
// R24 - Comparators are synchronous inputs; delays counted on clk.
module vr_sequence_and_phase_mode_ctrl
  import vr_seq_pkg::*;
#(
  parameter int START_DELAY_CYCLES = START_CYC,
  parameter int PHASES             = 8
)
(
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  input  wire logic                          enable_on,
  input  wire logic                          enable_off,
  input  wire logic                          output_at_reference,
  input  wire logic                          protection_trip,
  input  wire logic                          reference_level_low,
  input  wire logic                          reference_level_high,
  input  wire logic                          power_state_high,
  input  wire logic                          power_state_mid,
  input  wire logic                          smart_stage_mode,
  input  wire logic                          ramp_strap,
  input  wire logic [vr_seq_pkg::PHASE_W-1:0] low_phase_strap,
  input  wire logic [vr_seq_pkg::PHASE_W-1:0] boot_phase_strap,
  input  wire logic [PHASES-1:0]             phase_sense_inputs,
  input  wire logic [vr_seq_pkg::PHASE_W-1:0] auto_shed_phases,
  input  wire logic                          duty_voltage_select_in,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  output logic                               reg_ack,
  output logic      [PHASES-1:0]             phase_enable,
  output logic                               pwm_tristate,
  output logic                               pwm_low_pulse,
  output logic      [vr_seq_pkg::PHASE_W-1:0] active_phase_code,
  output logic                               soft_start_active,
  output logic                               soft_start_slew,
  output logic                               power_good_out_o,
  output logic                               power_good_out_oe,
  output logic                               reference_adjust_out,
  output logic                               reference_adjust_out_oe,
  output logic                               reference_level_nominal,
  output logic                               reference_level_discharge,
  output logic                               output_sense_discharge,
  output logic                               boot_mode,
  output logic                               standby_mode,
  output logic                               high_phase_mode,
  output logic                               auto_shed_mode,
  output logic                               low_phase_mode,
  output logic      [8*vr_seq_pkg::BAL_REGS-1:0] balance_settings,
  output logic      [1:0]                    total_balance_gain_a,
  output logic      [1:0]                    total_balance_gain_b
);
  import vr_seq_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (START_DELAY_CYCLES < 1 || START_DELAY_CYCLES >= (1 << DLY_W))
    $error("START_DELAY_CYCLES out of range");
  if (PHASES != (1 << PHASE_W))
    $error("PHASES must match the 3-bit phase code");

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_t         state;
  seq_state_t         next_state;
  phase_mode_t        mode;
  logic [DLY_W-1:0]   dly;
  logic               first_done;
  logic               seq_done;
  logic               fault;
  logic               power_good_out;
  logic [7:0]         cfg_slew;
  logic [7:0]         cfg_boot;
  logic [7:0]         cfg_low;
  logic [7:0]         cfg_tbal_a;
  logic [7:0]         cfg_tbal_b;
  logic [PHASE_W-1:0] max_code;
  logic [PHASE_W-1:0] next_code;
  logic [7:0]         bal [BAL_REGS];
  logic               wr_ok;
  logic               rd_ok;
  logic               switching;

  function automatic logic [PHASE_W-1:0] populated(input logic [PHASES-1:0] s);
    logic [PHASE_W-1:0] n;
    logic               run;
    n   = '0;
    run = 1'b1;
    for (int i = 1; i < PHASES; i++)
    begin
      run = run & s[i];
      if (run)
        n = PHASE_W'(i);
    end
    populated = n;
  endfunction : populated

  function automatic logic to_mask_bits(input logic [PHASE_W-1:0] c,
                                        input int i);
    to_mask_bits = (PHASE_W'(i) <= c);
  endfunction : to_mask_bits

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_OFF:
        if (enable_on && !fault)
          next_state = first_done ? S_DELAY : S_STRAP;             // [R01]
      S_STRAP:
        next_state = S_DELAY;
      S_DELAY:
        if (enable_off)
          next_state = S_OFF;
        else if (dly == '0)
          next_state = S_SOFT;                                     // [R02]
      S_SOFT, S_RUN, S_STANDBY:
        if (enable_off)
          next_state = S_STOP;                                     // [R07]
        else if (protection_trip)
          next_state = S_PULSE;                                    // [R23]
        else if (state == S_SOFT && output_at_reference)
          next_state = S_RUN;
        else if (state == S_RUN && reference_level_low)
          next_state = S_STANDBY;                                  // [R15]
        else if (state == S_STANDBY && reference_level_high)
          next_state = S_SOFT;                                     // [R16]
      S_STOP:
        if (dly == '0)
          next_state = S_PULSE;                                    // [R07]
      S_PULSE:
        if (dly == '0)
          next_state = S_OFF;                                      // [R09]
      default:
        next_state = S_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= S_OFF;
    else if (ce)
      state <= next_state;
  end

  // Shared delay counter, loaded on entry to each timed state
  always_ff @(posedge clk)
  begin
    if (srst)
      dly <= '0;
    else if (ce)
    begin
      if (next_state != state && next_state == S_DELAY)
        dly <= DLY_W'(START_DELAY_CYCLES - 1);                     // [R02] [R24]
      else if (next_state != state && next_state == S_STOP)
        dly <= DLY_W'(STOP_CYC - 1);                               // [R07] [R24]
      else if (next_state != state && next_state == S_PULSE)
        dly <= DLY_W'(OFF_PULSE_CYC - 1);                          // [R09]
      else if (dly != '0)
        dly <= dly - 1'b1;
    end
  end

  // Fault latch cleared only by enable going low
  always_ff @(posedge clk)
  begin
    if (srst)
      fault <= 1'b0;
    else if (ce)
    begin
      if (protection_trip && state inside {S_SOFT, S_RUN, S_STANDBY})
        fault <= 1'b1;
      else if (enable_off)
        fault <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      first_done <= 1'b0;
      seq_done   <= 1'b0;
    end
    else if (ce)
    begin
      if (state == S_STRAP)
        first_done <= 1'b1;
      if (next_state == S_RUN)
        seq_done <= 1'b1;                                          // [R06]
    end
  end

  // Power-good latch: held through standby, dropped when the stop delay ends or at trip
  always_ff @(posedge clk)
  begin
    if (srst)
      power_good_out <= 1'b0;
    else if (ce)
    begin
      if (next_state == S_PULSE || next_state == S_OFF)
        power_good_out <= 1'b0;                                             // [R08] [R23]
      else if (state == S_SOFT && next_state == S_RUN)
        power_good_out <= 1'b1;                                             // [R23] [R17]
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers, kept until power-on reset
  // ----------------------------------------------------------------
  assign wr_ok = reg_wr && seq_done;                               // [R06]
  assign rd_ok = reg_rd && seq_done;                               // [R06]

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_slew   <= REG_RESET;                                     // [R05]
      cfg_boot   <= REG_RESET;
      cfg_low    <= REG_RESET;
      cfg_tbal_a <= REG_RESET;
      cfg_tbal_b <= REG_RESET;
      max_code   <= '0;
    end
    else if (ce)
    begin
      if (state == S_STRAP)
      begin
        cfg_slew[SLEW_BIT]                <= ramp_strap;           // [R04]
        cfg_boot[BOOT_LSB+:PHASE_W]       <= boot_phase_strap;     // [R14]
        cfg_low[LOW_LSB+:PHASE_W]         <= low_phase_strap;      // [R20]
        max_code                          <= populated(phase_sense_inputs); // [R21]
      end
      else if (wr_ok)
      begin
        unique case (reg_addr)
          ADDR_SLEW:   cfg_slew   <= reg_wdata;
          ADDR_BOOT:   cfg_boot   <= reg_wdata;
          ADDR_LOW:    cfg_low    <= reg_wdata;
          ADDR_TBAL_A: cfg_tbal_a <= reg_wdata;                    // [R18]
          ADDR_TBAL_B: cfg_tbal_b <= reg_wdata;                    // [R18]
          default:     cfg_slew   <= cfg_slew;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < BAL_REGS; i++)
        bal[i] <= REG_RESET;
    end
    else if (ce && wr_ok && reg_addr >= ADDR_BAL_FIRST && reg_addr <= ADDR_BAL_LAST)
      bal[4'(reg_addr - ADDR_BAL_FIRST)] <= reg_wdata;             // [R18]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata <= '0;
      reg_ack   <= 1'b0;
    end
    else if (ce)
    begin
      reg_ack <= wr_ok || rd_ok;
      if (rd_ok)
      begin
        if (reg_addr >= ADDR_BAL_FIRST && reg_addr <= ADDR_BAL_LAST)
          reg_rdata <= bal[4'(reg_addr - ADDR_BAL_FIRST)];
        else if (reg_addr == ADDR_SLEW)
          reg_rdata <= cfg_slew;
        else if (reg_addr == ADDR_BOOT)
          reg_rdata <= cfg_boot;
        else if (reg_addr == ADDR_LOW)
          reg_rdata <= cfg_low;
        else if (reg_addr == ADDR_TBAL_A)
          reg_rdata <= cfg_tbal_a;
        else if (reg_addr == ADDR_TBAL_B)
          reg_rdata <= cfg_tbal_b;
        else
          reg_rdata <= '0;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < BAL_REGS; i++)
      balance_settings[8*i+:8] = bal[i];
  end

  assign total_balance_gain_a = cfg_tbal_a[TBAL_A_LSB+:2];         // [R18]
  assign total_balance_gain_b = cfg_tbal_b[TBAL_B_LSB+:2];         // [R18]
  assign soft_start_slew      = cfg_slew[SLEW_BIT];                // [R04]

  // ----------------------------------------------------------------
  // Phase mode and count
  // ----------------------------------------------------------------
  always_comb
  begin
    if (power_state_high)
      mode = MODE_HIGH;
    else if (power_state_mid)
      mode = MODE_AUTO;                                            // [R22]
    else
      mode = MODE_LOW;
  end

  phase_count_select u_count (
    .mode       (mode),
    .boot       (boot_mode),
    .boot_code  (cfg_boot[BOOT_LSB+:PHASE_W]),
    .low_code   (cfg_low[LOW_LSB+:PHASE_W]),
    .max_code   (max_code),
    .auto_code  (auto_shed_phases),
    .count_code (next_code)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
      active_phase_code <= '0;
    else if (ce)
      active_phase_code <= next_code;                              // [R14] [R20]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      reference_adjust_out <= 1'b0;
    else if (ce)
      reference_adjust_out <= duty_voltage_select_in;              // [R12]
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  assign switching = state inside {S_SOFT, S_RUN, S_STOP};
  always_comb
  begin
    for (int i = 0; i < PHASES; i++)
      phase_enable[i] = switching && to_mask_bits(active_phase_code, i);
  end

  assign pwm_tristate      = !switching && state != S_PULSE;       // [R03] [R07] [R15]
  assign pwm_low_pulse     = state == S_PULSE;                     // [R09]
  assign soft_start_active = state == S_SOFT;
  assign boot_mode         = state inside {S_DELAY, S_SOFT};       // [R14]
  assign standby_mode      = state == S_STANDBY;
  assign high_phase_mode   = mode == MODE_HIGH;
  assign auto_shed_mode    = mode == MODE_AUTO;
  assign low_phase_mode    = mode == MODE_LOW;
  assign power_good_out_o  = 1'b0;
  assign power_good_out_oe = !power_good_out;                               // [R08]
  assign reference_adjust_out_oe = power_good_out && state inside {S_RUN, S_STANDBY}; // [R13]
  assign reference_level_nominal = smart_stage_mode && state == S_DELAY;    // [R03]
  assign reference_level_discharge = smart_stage_mode &&
    (state inside {S_STOP, S_PULSE} || (state == S_OFF && first_done));     // [R11]
  assign output_sense_discharge = state == S_PULSE || (state == S_OFF && first_done); // [R10]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_retoggle_skip: assert property (@(posedge clk) disable iff (srst) // [R01]
    ce && state == S_OFF && first_done && enable_on && !fault |=> state == S_DELAY)
    else $error("re-toggle did not skip strap detection");

  a_delay_tristate: assert property (@(posedge clk) disable iff (srst) // [R03]
    state == S_DELAY |-> pwm_tristate && phase_enable == '0
      && reference_level_nominal == smart_stage_mode)
    else $error("phases driven during start delay");

  a_reg_locked: assert property (@(posedge clk) disable iff (srst) // [R06]
    ce && (reg_wr || reg_rd) && !seq_done |=> !reg_ack)
    else $error("register access before sequence end");

  a_stop_timing: assert property (@(posedge clk) disable iff (srst) // [R07]
    ce && state == S_RUN && enable_off |=> state == S_STOP && dly == DLY_W'(STOP_CYC - 1))
    else $error("stop delay not started");

  a_pulse_power_good_out: assert property (@(posedge clk) disable iff (srst) // [R08]
    state == S_PULSE |-> power_good_out_oe && pwm_low_pulse && !pwm_tristate)
    else $error("off pulse without power-good low");

  a_off_discharge: assert property (@(posedge clk) disable iff (srst) // [R10]
    $rose(state == S_PULSE) |-> output_sense_discharge)
    else $error("output discharge missing at power-off");

  a_reference_adjust_out_hiz: assert property (@(posedge clk) disable iff (srst) // [R13]
    !power_good_out || boot_mode |-> !reference_adjust_out_oe)
    else $error("reference adjust driven before power-good");

  a_reference_adjust_out_follow: assert property (@(posedge clk) disable iff (srst) // [R12]
    ce && state == S_RUN ##1 ce |-> reference_adjust_out == $past(duty_voltage_select_in))
    else $error("reference adjust not following duty input");

  a_standby_power_good_out: assert property (@(posedge clk) disable iff (srst) // [R17]
    state == S_STANDBY |-> !power_good_out_oe && pwm_tristate)
    else $error("power-good or phases wrong in standby");

  a_slew_kept: assert property (@(posedge clk) disable iff (srst) // [R04]
    first_done && !wr_ok |=> $stable(soft_start_slew))
    else $error("slew setting changed without a register write");

endmodule : vr_sequence_and_phase_mode_ctrl

// *** tb/gpu_host_model.sv ***
// Host model: duty voltage-select stream and standby control.
// Assumes the bench raises standby_req; lines change at falling edge.
`timescale 1ns/1ps
module gpu_host_model
(
  input  wire logic clk,
  input  wire logic standby_req,
  output logic      duty_voltage_select_in,
  output logic      reference_level_low,
  output logic      reference_level_high
);
  initial duty_voltage_select_in = 1'b0;
  // Standby pulls the reference below entry, release lifts it above exit
  assign reference_level_low  = standby_req;
  assign reference_level_high = !standby_req;
  always @(negedge clk)
  begin
    duty_voltage_select_in <= 1'($urandom_range(1, 0));
  end
endmodule : gpu_host_model

// *** tb/vr_sequence_and_phase_mode_ctrl_bench.sv ***
// Bench of the regulator sequencer with a host model on the far side.
// Assumes a shortened start delay of 20 cycles.
`timescale 1ns/1ps
module vr_sequence_and_phase_mode_ctrl_bench;
  import vr_seq_pkg::*;
  logic clk = 0, srst = 1, ce = 1, enable_on = 0, enable_off = 1, output_at_reference = 0;
  logic protection_trip = 0, power_state_high = 0, power_state_mid = 0, smart_stage_mode = 1;
  logic ramp_strap = 1, reg_wr = 0, reg_rd = 0, standby_req = 0;
  logic reference_level_low, reference_level_high, duty_voltage_select_in;
  logic [2:0] low_phase_strap = 3'h2, boot_phase_strap = 3'h1, auto_shed_phases = 3'h0;
  logic [7:0] phase_sense_inputs = 8'hFF, reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, phase_enable, rd, wd, bootv;
  logic [2:0] active_phase_code;
  logic reg_ack, pwm_tristate, pwm_low_pulse, soft_start_active, soft_start_slew, ack, d;
  logic power_good_out_o, power_good_out_oe, reference_adjust_out, reference_adjust_out_oe;
  logic reference_level_nominal, reference_level_discharge, output_sense_discharge, boot_mode;
  logic standby_mode, high_phase_mode, auto_shed_mode, low_phase_mode;
  logic [127:0] balance_settings;
  logic [1:0] total_balance_gain_a, total_balance_gain_b;
  int n_errors = 0, total_checks = 0, cnt, cnt1;

  vr_sequence_and_phase_mode_ctrl #(.START_DELAY_CYCLES(20)) u_vr_sequence_and_phase_mode_ctrl (.*);
  gpu_host_model u_gpu_host_model (.*);

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] w);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, w};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
    ack = reg_ack;
    @(negedge clk);
    ack = ack | reg_ack;
    rd = reg_rdata;
  endtask : acc

  task automatic wait_soft(output int n);
    n = 0;
    while (soft_start_active !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
      if (n > 2 && soft_start_active !== 1'b1)
      begin
        check(pwm_tristate, 1);
        check(reference_level_nominal, 1);
        check(reference_adjust_out_oe, 0);
      end
    end
    check(boot_mode, 1);
    output_at_reference = 1;
    repeat (3) @(negedge clk);
    check(power_good_out_oe, 0);
  endtask : wait_soft

  initial
  begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hC974));
    repeat (7) @(negedge clk);
    srst = 0;
    acc(1, ADDR_BOOT, 8'h0A);
    check(ack, 0);
    {enable_off, enable_on} = 2'b01;
    wait_soft(cnt1);
    check(cnt1 >= 20, 1);
    repeat (8)
    begin
      @(posedge clk);
      d = duty_voltage_select_in;
      @(negedge clk);
      check(reference_adjust_out, d);
      check(reference_adjust_out_oe, 1);
    end
    $display("power-on done");
    for (int m = 0; m < 3; m++)
    begin
      {power_state_high, power_state_mid} = 2'b10 >> m;
      auto_shed_phases = 3'($urandom_range(6, 0));
      wd = {1'b0, 3'($urandom_range(6, 0)), 4'h0};
      acc(1, ADDR_LOW, wd);
      repeat (3) @(negedge clk);
      check({high_phase_mode, auto_shed_mode, low_phase_mode}, 3'b100 >> m);
      check(active_phase_code, m == 0 ? 3'h7 : m == 1 ? auto_shed_phases : wd[6:4]);
    end
    bootv = {4'h0, 3'($urandom_range(7, 0)), 1'b0};
    acc(1, ADDR_BOOT, bootv);
    check(ack, 1);
    wd = 8'($urandom);
    acc(1, 8'h13, wd);
    acc(1, ADDR_TBAL_A, wd);
    check(balance_settings[16+:8], wd);
    check(total_balance_gain_a, wd[4:3]);
    acc(0, 8'hFE, 8'h00);
    check(rd, 0);
    $display("registers done");
    {enable_off, enable_on, ramp_strap} = 3'b100;
    cnt = 0;
    while (pwm_low_pulse !== 1'b1 && cnt < 50)
    begin
      @(negedge clk);
      cnt++;
    end
    check(cnt, STOP_CYC + 1);
    check(power_good_out_oe, 1);
    check(phase_enable, 0);
    check({output_sense_discharge, reference_level_discharge}, 2'b11);
    @(negedge clk);
    check(pwm_tristate, 1);
    $display("power-off done");
    {enable_off, enable_on, output_at_reference} = 3'b010;
    wait_soft(cnt);
    check(cnt1 - cnt, 1);
    check(soft_start_slew, 1);
    acc(0, ADDR_BOOT, 8'h00);
    check(rd, bootv);
    $display("re-toggle done");
    standby_req = 1;
    repeat (3) @(negedge clk);
    check({standby_mode, pwm_tristate, power_good_out_oe}, 3'b110);
    {standby_req, output_at_reference} = 2'b00;
    repeat (3) @(negedge clk);
    check({standby_mode, power_good_out_oe}, 2'b00);
    check(active_phase_code, bootv[3:1]);
    {ce, enable_off, enable_on} = 3'b010;
    repeat (3) @(negedge clk);
    check({soft_start_active, pwm_tristate}, 2'b10);
    ce = 1;
    $display("standby done");
    tally_and_finish();
  end
endmodule : vr_sequence_and_phase_mode_ctrl_bench
